// ==== common/adpc_pkg.sv ====
package adpc_pkg;
	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_CFG     = 8'h04;
	localparam logic [7:0] OFS_RES_HI  = 8'h08;
	localparam logic [7:0] OFS_RES_LO  = 8'h0c;
	localparam logic [7:0] OFS_CMP     = 8'h10;
	localparam logic [7:0] OFS_PIN_LO  = 8'h14;
	localparam logic [7:0] OFS_PIN_MID = 8'h18;
	localparam logic [7:0] OFS_PIN_HI  = 8'h1c;
	////////////////////////////////////////////////////////////////////////////
	// Field layout
	localparam int         CH_W        = 5;
	localparam int         CTRL_COMPARE_ENABLE   = 5;
	localparam int         CTRL_CONVERSION_DONE_IRQ_ENABLE   = 6;
	localparam int         CTRL_DONE   = 7;
	localparam int         CTRL_GT     = 8;
	localparam int         CFG_SRC     = 0;
	localparam int         CFG_MODE    = 2;
	localparam int         CFG_DIV     = 4;
	localparam int         GRP_W       = 8;
	////////////////////////////////////////////////////////////////////////////
	// Codes and reset values
	localparam logic [4:0] CH_OFF      = 5'h1f;
	localparam logic [1:0] SRC_BUS     = 2'h0;
	localparam logic [1:0] SRC_HALF    = 2'h1;
	localparam logic [1:0] SRC_ALT     = 2'h2;
	localparam logic [1:0] SRC_ASYNC   = 2'h3;
	localparam logic [1:0] MODE_8      = 2'h0;
	localparam logic [1:0] MODE_10     = 2'h2;
	localparam logic [1:0] DIV_1       = 2'h0;
	localparam logic [7:0] PIN_RST     = 8'h00;
	localparam logic [9:0] CMP_RST     = 10'h000;
	localparam logic [2:0] SIZE_WORD   = 3'h2;
	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {ST_DISABLED, ST_IDLE, ST_CONVERT} adpc_state_t;
endpackage

// ==== src/adpc_pin_gate.sv ====
`timescale 1ns/100ps
module adpc_pin_gate #(
	parameter int PW = 8
) (
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic [PW-1:0] release_bits,
	input  wire logic [PW-1:0] port_out,
	input  wire logic [PW-1:0] port_oe,
	input  wire logic [PW-1:0] port_pullup,
	input  wire logic [PW-1:0] pad_in,
	output logic      [PW-1:0] pad_out,
	output logic      [PW-1:0] pad_oe,
	output logic      [PW-1:0] pad_pullup,
	output logic      [PW-1:0] pad_in_enable,
	output logic      [PW-1:0] port_read
);
	if (PW < 1) begin : g_bad
		$error("adpc_pin_gate: PW must be at least 1");
	end
	logic [PW-1:0] s1, s2, s3, stable;
	////////////////////////////////////////////////////////////////////////////
	// Pad input synchroniser, filtered on agreement of stages two and three
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			stable <= '0;
		end else begin
			s1 <= pad_in;
			s2 <= s1;
			s3 <= s2;
			stable <= (s2 & ~(s2 ^ s3)) | (stable & (s2 ^ s3));
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Released pins: hi-z, input off, pullup off
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pad_out <= '0;
			pad_oe <= '0;
			pad_pullup <= '0;
			pad_in_enable <= '1;
			port_read <= '0;
		end else begin
			pad_out <= port_out & ~release_bits;
			pad_oe <= port_oe & ~release_bits;
			pad_pullup <= port_pullup & ~release_bits;
			pad_in_enable <= ~release_bits;
			port_read <= stable & ~release_bits;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	chk_release_hiz: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> ((pad_oe | pad_pullup | port_read) & $past(release_bits)) == '0)
		else $error("released pin still driven, pulled or read");
	chk_port_keep: assert property (@(posedge hclk) disable iff (!hresetn)
		hresetn |=> pad_oe == ($past(port_oe) & ~$past(release_bits)))
		else $error("unreleased pin lost port control");
endmodule // adpc_pin_gate

// ==== src/adpc_clkgen.sv ====
`timescale 1ns/100ps
module adpc_clkgen (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       run,
	input  wire logic       sleep_mode,
	input  wire logic [1:0] src_sel,
	input  wire logic [1:0] div_sel,
	input  wire logic       alternate_clock,
	input  wire logic       internal_async_conv_clock,
	output logic            converter_clock,
	output logic            async_clock_enable
);
	import adpc_pkg::*;
	logic [1:0] s1, s2, s3, stable, stable_d;
	logic       half;
	logic [2:0] cnt;
	logic       src_tick;
	logic [2:0] lim;
	////////////////////////////////////////////////////////////////////////////
	// Sampled outside clocks, edge counted once stages two and three agree
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			stable <= '0;
			stable_d <= '0;
		end else begin
			s1 <= {internal_async_conv_clock, alternate_clock};
			s2 <= s1;
			s3 <= s2;
			stable <= (s2 & ~(s2 ^ s3)) | (stable & (s2 ^ s3));
			stable_d <= stable;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Async source kept alive in wait and stop3 while converting
	assign async_clock_enable = run && src_sel == SRC_ASYNC;
	always_comb begin
		case (src_sel)
			SRC_BUS:   src_tick = !sleep_mode;
			SRC_HALF:  src_tick = !sleep_mode && half;
			SRC_ALT:   src_tick = !sleep_mode && stable[0] && !stable_d[0];
			SRC_ASYNC: src_tick = stable[1] && !stable_d[1];
			default:   src_tick = 1'b0;
		endcase
	end
	assign lim = 3'((4'h1 << div_sel) - 4'h1);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			half <= 1'b0;
			cnt <= '0;
			converter_clock <= 1'b0;
		end else if (!run) begin
			half <= 1'b0;
			cnt <= '0;
			converter_clock <= 1'b0;
		end else begin
			half <= ~half;
			converter_clock <= src_tick && cnt == lim;
			if (src_tick) begin
				cnt <= (cnt == lim) ? 3'h0 : cnt + 3'h1;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	logic [4:0] gap;
	logic       gap_ok;
	logic [4:0] gap_exp;
	assign gap_exp = 5'(((src_sel == SRC_HALF) ? 6'h2 : 6'h1) << div_sel);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gap <= '0;
			gap_ok <= 1'b0;
		end else if (!run || sleep_mode || src_sel[1] || $changed(div_sel)
				|| $changed(src_sel)) begin
			gap <= '0;
			gap_ok <= 1'b0;
		end else if (converter_clock) begin
			gap <= 5'h1;
			gap_ok <= 1'b1;
		end else if (gap != 5'h1f) begin
			gap <= gap + 5'h1;
		end
	end
	chk_div_ratio: assert property (@(posedge hclk) disable iff (!hresetn)
		converter_clock && gap_ok && $past(run) && !$changed(div_sel)
			&& !$changed(src_sel) && !src_sel[1] |-> gap == gap_exp)
		else $error("converter clock period does not match divide setting");
	chk_bus_default: assert property (@(posedge hclk) disable iff (!hresetn)
		run && $past(run) && !sleep_mode && !$past(sleep_mode) && src_sel == SRC_BUS
			&& div_sel == DIV_1 && $stable(src_sel) |=> converter_clock)
		else $error("undivided bus clock did not tick every cycle");
	chk_async_awake: assert property (@(posedge hclk) disable iff (!hresetn)
		run && src_sel == SRC_ASYNC && sleep_mode && stable[1] && !stable_d[1] && cnt == lim
			|=> converter_clock)
		else $error("async converter clock stopped in low power mode");
	cov_half_div8: cover property (@(posedge hclk) disable iff (!hresetn)
		converter_clock && gap_ok && src_sel == SRC_HALF && div_sel == 2'h3);
endmodule // adpc_clkgen

// ==== src/adpc_top.sv ====
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
module adpc_top #(
	parameter int NCH = 24
) (
	input  wire logic                       hclk,
	input  wire logic                       hresetn,
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic                            hreadyout,
	output logic                            hresp,
	output logic      [31:0]                hrdata,
	input  wire logic                       sleep_mode,
	input  wire logic                       alternate_clock,
	input  wire logic                       internal_async_conv_clock,
	output logic                            converter_clock,
	output logic                            async_clock_enable,
	output logic                            conv_start,
	output logic                            conv_busy,
	output logic                            conv_disabled,
	output logic      [adpc_pkg::CH_W-1:0]  conv_channel,
	output logic                            conv_mode_10bit,
	input  wire logic                       sar_done,
	input  wire logic [10:0]                sar_value,
	output logic                            conversion_done_irq,
	input  wire logic [NCH-1:0]             port_out,
	input  wire logic [NCH-1:0]             port_oe,
	input  wire logic [NCH-1:0]             port_pullup,
	input  wire logic [NCH-1:0]             pad_in,
	output logic      [NCH-1:0]             pad_out,
	output logic      [NCH-1:0]             pad_oe,
	output logic      [NCH-1:0]             pad_pullup,
	output logic      [NCH-1:0]             pad_in_enable,
	output logic      [NCH-1:0]             port_read
);
	import adpc_pkg::*;
	if (NCH != 3 * GRP_W) begin : g_bad
		$error("adpc_top: NCH must be three pin groups");
	end
	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: writes zero wait, reads one wait state
	logic        ap_write;
	logic        rd_pend;
	logic [7:0]  ap_addr;
	logic [31:0] rd_mux;
	logic        addr_take;
	assign addr_take = hsel && hready && htrans[1] && hsize == SIZE_WORD;
	assign hreadyout = !rd_pend;
	assign hresp = 1'b0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_write <= 1'b0;
			rd_pend <= 1'b0;
			ap_addr <= '0;
		end else begin
			ap_write <= addr_take && hwrite;
			rd_pend <= addr_take && !hwrite;
			if (addr_take) begin
				ap_addr <= haddr[7:0];
			end
		end
	end
	logic wr_ctrl, wr_cfg, wr_cmp, rd_lo;
	assign wr_ctrl = ap_write && ap_addr == OFS_CTRL;
	assign wr_cfg = ap_write && ap_addr == OFS_CFG;
	assign wr_cmp = ap_write && ap_addr == OFS_CMP;
	assign rd_lo = rd_pend && ap_addr == OFS_RES_LO;
	////////////////////////////////////////////////////////////////////////////
	// Control and configuration registers
	logic [CH_W-1:0] channel_select_field;
	logic            compare_enable;
	logic            compare_greater;
	logic            conversion_done_irq_enable;
	logic [1:0]      conv_clock_source_select;
	logic [1:0]      conv_mode;
	logic [1:0]      conv_clock_divide;
	logic [9:0]      compare_value;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			channel_select_field <= CH_OFF;
			compare_enable <= 1'b0;
			compare_greater <= 1'b0;
			conversion_done_irq_enable <= 1'b0;
		end else if (wr_ctrl) begin
			channel_select_field <= hwdata[CH_W-1:0];
			compare_enable <= hwdata[CTRL_COMPARE_ENABLE];
			compare_greater <= hwdata[CTRL_GT];
			conversion_done_irq_enable <= hwdata[CTRL_CONVERSION_DONE_IRQ_ENABLE];
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			conv_clock_source_select <= SRC_BUS;
			conv_mode <= MODE_8;
			conv_clock_divide <= DIV_1;
			compare_value <= CMP_RST;
		end else begin
			if (wr_cfg) begin
				conv_clock_source_select <= hwdata[CFG_SRC+:2];
				conv_mode <= hwdata[CFG_MODE+:2];
				conv_clock_divide <= hwdata[CFG_DIV+:2];
			end
			if (wr_cmp) begin
				compare_value <= hwdata[9:0];
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Pin release registers
	logic [GRP_W-1:0] analog_pin_release_low;
	logic [GRP_W-1:0] analog_pin_release_mid;
	logic [GRP_W-1:0] analog_pin_release_high;
	logic [NCH-1:0]   release_vec;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			analog_pin_release_low <= PIN_RST;
			analog_pin_release_mid <= PIN_RST;
			analog_pin_release_high <= PIN_RST;
		end else if (ap_write) begin
			if (ap_addr == OFS_PIN_LO) begin
				analog_pin_release_low <= hwdata[GRP_W-1:0];
			end
			if (ap_addr == OFS_PIN_MID) begin
				analog_pin_release_mid <= hwdata[GRP_W-1:0];
			end
			if (ap_addr == OFS_PIN_HI) begin
				analog_pin_release_high <= hwdata[GRP_W-1:0];
			end
		end
	end
	// Bit n of the vector is channel n
	assign release_vec = {analog_pin_release_high, analog_pin_release_mid,
		analog_pin_release_low};
	for (genvar g = 0; g < 3; g++) begin : g_pins
		adpc_pin_gate #(.PW(GRP_W)) u_gate (
			.hclk         (hclk),
			.hresetn      (hresetn),
			.release_bits (release_vec[g*GRP_W+:GRP_W]),
			.port_out     (port_out[g*GRP_W+:GRP_W]),
			.port_oe      (port_oe[g*GRP_W+:GRP_W]),
			.port_pullup  (port_pullup[g*GRP_W+:GRP_W]),
			.pad_in       (pad_in[g*GRP_W+:GRP_W]),
			.pad_out      (pad_out[g*GRP_W+:GRP_W]),
			.pad_oe       (pad_oe[g*GRP_W+:GRP_W]),
			.pad_pullup   (pad_pullup[g*GRP_W+:GRP_W]),
			.pad_in_enable(pad_in_enable[g*GRP_W+:GRP_W]),
			.port_read    (port_read[g*GRP_W+:GRP_W])
		);
	end
	////////////////////////////////////////////////////////////////////////////
	// Converter state
	adpc_state_t state, next_state;
	logic        start;
	logic        sar_ok;
	assign start = wr_ctrl && hwdata[CH_W-1:0] != CH_OFF;
	assign sar_ok = state == ST_CONVERT && sar_done && !wr_ctrl && !wr_cfg && !wr_cmp;
	always_comb begin
		next_state = state;
		case (state)
			ST_DISABLED: begin
				if (start) begin
					next_state = ST_CONVERT;
				end
			end
			ST_IDLE: begin
				if (start) begin
					next_state = ST_CONVERT;
				end else if (channel_select_field == CH_OFF) begin
					next_state = ST_DISABLED;
				end
			end
			ST_CONVERT: begin
				if (wr_ctrl) begin
					next_state = start ? ST_CONVERT : ST_DISABLED;
				end else if (wr_cfg || wr_cmp || sar_done) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_DISABLED;
		endcase
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_DISABLED;
			conv_start <= 1'b0;
		end else begin
			state <= next_state;
			conv_start <= start;
		end
	end
	assign conv_busy = state == ST_CONVERT;
	assign conv_disabled = state == ST_DISABLED;
	assign conv_channel = channel_select_field;
	assign conv_mode_10bit = conv_mode == MODE_10;
	adpc_clkgen u_clk (
		.hclk                     (hclk),
		.hresetn                  (hresetn),
		.run                      (conv_busy),
		.sleep_mode               (sleep_mode),
		.src_sel                  (conv_clock_source_select),
		.div_sel                  (conv_clock_divide),
		.alternate_clock          (alternate_clock),
		.internal_async_conv_clock(internal_async_conv_clock),
		.converter_clock          (converter_clock),
		.async_clock_enable       (async_clock_enable)
	);
	////////////////////////////////////////////////////////////////////////////
	// Rounding, compare and result store
	logic [9:0] rnd;
	logic       cmp_ok;
	logic       store;
	always_comb begin
		if (conv_mode_10bit) begin
			rnd = (sar_value[10:1] == 10'h3ff) ? 10'h3ff
				: sar_value[10:1] + {9'h0, sar_value[0]};
			cmp_ok = compare_greater ? (rnd >= compare_value) : (rnd < compare_value);
		end else begin
			rnd = {2'h0, (sar_value[8:1] == 8'hff) ? 8'hff
				: sar_value[8:1] + {7'h0, sar_value[0]}};
			cmp_ok = compare_greater ? (rnd[7:0] >= compare_value[7:0])
				: (rnd[7:0] < compare_value[7:0]);
		end
	end
	assign store = sar_ok && (!compare_enable || cmp_ok);
	logic [1:0] result_high_reg;
	logic [7:0] result_low_reg;
	logic       conversion_done_flag;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			result_high_reg <= '0;
			result_low_reg <= '0;
		end else if (store) begin
			result_high_reg <= conv_mode_10bit ? rnd[9:8] : 2'h0;
			result_low_reg <= rnd[7:0];
		end
	end
	// Set beats a same-cycle clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			conversion_done_flag <= 1'b0;
		end else begin
			conversion_done_flag <= store || (conversion_done_flag && !wr_ctrl && !rd_lo);
		end
	end
	assign conversion_done_irq = conversion_done_flag && conversion_done_irq_enable;
	////////////////////////////////////////////////////////////////////////////
	// Read data
	always_comb begin
		case (ap_addr)
			OFS_CTRL:    rd_mux = 32'({compare_greater, conversion_done_flag,
				conversion_done_irq_enable, compare_enable, channel_select_field});
			OFS_CFG:     rd_mux = 32'({conv_clock_divide, conv_mode, conv_clock_source_select});
			OFS_RES_HI:  rd_mux = 32'(result_high_reg);
			OFS_RES_LO:  rd_mux = 32'(result_low_reg);
			OFS_CMP:     rd_mux = 32'(compare_value);
			OFS_PIN_LO:  rd_mux = 32'(analog_pin_release_low);
			OFS_PIN_MID: rd_mux = 32'(analog_pin_release_mid);
			OFS_PIN_HI:  rd_mux = 32'(analog_pin_release_high);
			default:     rd_mux = 32'h0;
		endcase
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
		end else if (rd_pend) begin
			hrdata <= rd_mux;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	chk_round_ten: assert property (@(posedge hclk) disable iff (!hresetn)
		store && conv_mode_10bit |=> {result_high_reg, result_low_reg} == $past(rnd))
		else $error("ten-bit result not rounded into result registers");
	chk_round_eight: assert property (@(posedge hclk) disable iff (!hresetn)
		store && !conv_mode_10bit |=> result_high_reg == 2'h0
			&& result_low_reg == $past(rnd[7:0]))
		else $error("eight-bit result not rounded into low result");
	chk_done_set: assert property (@(posedge hclk) disable iff (!hresetn)
		store && conversion_done_irq_enable && !wr_ctrl |=> conversion_done_flag
			&& conversion_done_irq)
		else $error("stored result did not raise done flag and interrupt");
	chk_cmp_block: assert property (@(posedge hclk) disable iff (!hresetn)
		sar_ok && compare_enable && !cmp_ok |=> $stable(result_low_reg)
			&& $stable(result_high_reg))
		else $error("result stored although compare condition failed");
	chk_idle_after: assert property (@(posedge hclk) disable iff (!hresetn)
		sar_ok |=> state == ST_IDLE && !conv_busy)
		else $error("converter not idle after finished conversion");
	chk_disabled_sel: assert property (@(posedge hclk) disable iff (!hresetn)
		state == ST_DISABLED |-> channel_select_field == CH_OFF)
		else $error("converter disabled with a valid channel selected");
	chk_off_stays: assert property (@(posedge hclk) disable iff (!hresetn)
		state != ST_CONVERT && channel_select_field == CH_OFF && !wr_ctrl
			|=> state == ST_DISABLED)
		else $error("converter not disabled with all ones channel select");
	cov_ten_store: cover property (@(posedge hclk) disable iff (!hresetn)
		store && conv_mode_10bit);
	cov_cmp_miss: cover property (@(posedge hclk) disable iff (!hresetn)
		sar_ok && compare_enable && !cmp_ok);
	cov_set_clear: cover property (@(posedge hclk) disable iff (!hresetn)
		store && rd_lo);
endmodule // adpc_top

// ==== dv/adpc_analog_model.sv ====
`timescale 1ns/100ps
module adpc_analog_model (
	input  wire logic        hclk,
	input  wire logic        conv_start,
	input  wire logic        async_clock_enable,
	input  wire logic [8:0]  lat,
	input  wire logic [10:0] raw,
	output logic             sar_done,
	output logic [10:0]      sar_value,
	output logic             alternate_clock,
	output logic             internal_async_conv_clock
);
	initial begin
		sar_done = 1'b0;
		sar_value = 11'h000;
		forever begin
			@(negedge hclk iff conv_start === 1'b1);
			repeat (lat) @(posedge hclk);
			sar_done <= 1'b1;
			sar_value <= raw;
			@(posedge hclk);
			sar_done <= 1'b0;
			// Stale value is not held
			sar_value <= ~raw;
		end
	end
	// Generator runs only while enabled
	always #7 internal_async_conv_clock = async_clock_enable ? ~internal_async_conv_clock : 1'b0;
	always #23 alternate_clock = (alternate_clock !== 1'b1);
endmodule // adpc_analog_model

// ==== dv/adc_pin_clock_result_control_test.sv ====
`timescale 1ns/100ps
module adc_pin_clock_result_control_test;
	import adpc_pkg::*;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sleep_mode = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = SIZE_WORD;
	logic        hreadyout, hresp, alternate_clock, internal_async_conv_clock, converter_clock;
	logic        async_clock_enable, conv_start, conv_busy, conv_disabled, conv_mode_10bit;
	logic        sar_done, conversion_done_irq;
	logic [4:0]  conv_channel;
	logic [10:0] sar_value, raw = 0;
	logic [8:0]  lat = 9'd20;
	logic [23:0] port_out = 24'hc3c3c3, port_oe = '1, port_pullup = '1, pad_in = '1;
	logic [23:0] pad_out, pad_oe, pad_pullup, pad_in_enable, port_read;
	int          fail_count = 0, tests_run = 0;
	always #5 hclk = ~hclk;
	adpc_top dut (.hready(hreadyout), .*);
	adpc_analog_model far_side (.*);
	////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wait_ready();
		logic r;
		do begin
			@(negedge hclk);
			r = hreadyout;
			rd = hrdata;
			@(posedge hclk);
		end while (r !== 1'b1);
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h0, a};
		wait_ready();
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
	endtask
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(what, rd, exp);
		chk("hresp", hresp, 1'b0);
	endtask
	task automatic wait_done();
		repeat (3) @(negedge hclk);
		for (int n = 0; n < 400 && conv_busy !== 1'b0; n++) @(negedge hclk);
		chk("busy_end", conv_busy, 1'b0);
		@(posedge hclk);
	endtask
	task automatic conv(input logic [31:0] cfg, ctl, input logic [10:0] v,
			input logic [31:0] hi, lo, input logic irq);
		bus(1'b1, OFS_CFG, cfg);
		raw <= v;
		bus(1'b1, OFS_CTRL, ctl);
		@(negedge hclk);
		chk("start", conv_start, 1'b1);
		wait_done();
		chk("irq", conversion_done_irq, irq);
		rdchk("res_hi", OFS_RES_HI, hi);
		rdchk("res_lo", OFS_RES_LO, lo);
	endtask
	////////////////////////////////////////
	task automatic t_reset();
		chk("disabled", conv_disabled, 1'b1);
		rdchk("ctrl", OFS_CTRL, 32'h1f);
		rdchk("cfg", OFS_CFG, 32'h0);
		rdchk("pin_lo", OFS_PIN_LO, 32'h0);
		rdchk("pin_mid", OFS_PIN_MID, 32'h0);
		rdchk("pin_hi", OFS_PIN_HI, 32'h0);
	endtask
	task automatic t_pins();
		bus(1'b1, OFS_PIN_LO, 32'h81);
		bus(1'b1, OFS_PIN_MID, 32'h01);
		bus(1'b1, OFS_PIN_HI, 32'h80);
		repeat (8) @(negedge hclk);
		chk("pad_oe", pad_oe, 32'h7ffe7e);
		chk("pad_out", pad_out, 32'h43c242);
		chk("pad_pullup", pad_pullup, 32'h7ffe7e);
		chk("pad_in_enable", pad_in_enable, 32'h7ffe7e);
		chk("port_read", port_read, 32'h7ffe7e);
		@(posedge hclk);
		rdchk("pin_mid", OFS_PIN_MID, 32'h01);
	endtask
	task automatic t_eight();
		conv(32'h00, 32'h43, 11'h1ff, 32'h0, 32'hff, 1'b1);
	endtask
	task automatic t_ten();
		conv(32'h08, 32'h43, 11'h2a5, 32'h1, 32'h53, 1'b1);
		chk("mode10", conv_mode_10bit, 1'b1);
		chk("idle", conv_busy, 1'b0);
		chk("irq_clr", conversion_done_irq, 1'b0);
		rdchk("ctrl", OFS_CTRL, 32'h43);
		bus(1'b1, OFS_CTRL, 32'h1f);
		@(negedge hclk);
		chk("no_start", conv_start, 1'b0);
		repeat (2) @(negedge hclk);
		chk("disabled", conv_disabled, 1'b1);
		chk("channel", conv_channel, 32'h1f);
		@(posedge hclk);
	endtask
	task automatic t_compare();
		bus(1'b1, OFS_CMP, 32'h010);
		conv(32'h08, 32'h63, 11'h3fe, 32'h1, 32'h53, 1'b0);
		conv(32'h08, 32'h163, 11'h3fe, 32'h1, 32'hff, 1'b1);
	endtask
	task automatic t_clock();
		logic [7:0] ccfg [6] = '{8'h00, 8'h10, 8'h01, 8'h31, 8'h02, 8'h23};
		int         nexp [6] = '{64, 32, 32, 4, 13, 0};
		int         n;
		lat <= 9'd200;
		for (int i = 0; i < 6; i++) begin
			// Source and divider keep the clock in range
			bus(1'b1, OFS_CFG, {24'h0, ccfg[i]});
			sleep_mode <= (i == 5);
			bus(1'b1, OFS_CTRL, 32'h03);
			repeat (8) @(negedge hclk);
			n = 0;
			repeat (64) begin
				@(negedge hclk);
				n += converter_clock;
			end
			if (i < 4) begin
				chk("converter_clock_count", n, nexp[i]);
			end else if (i == 4) begin
				chk("alt_count", n >= nexp[i] && n <= nexp[i] + 1, 1'b1);
			end else begin
				chk("async_on", async_clock_enable, 1'b1);
				chk("async_runs", n != 0, 1'b1);
			end
			wait_done();
		end
	endtask
	////////////////////////////////////////
	task automatic tally_and_finish();
		if (fail_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_pins();
		t_eight();
		t_ten();
		t_compare();
		t_clock();
		tally_and_finish();
	end
	initial begin
		#200000;
		fail_count++;
		tally_and_finish();
	end
endmodule // adc_pin_clock_result_control_test
